// file: pkg/sba_pkg.sv
// sba_pkg: constants and types shared by the burst access arbiter.
// assumes a 32-bit byte-addressed processor bus and a 16K-word memory.
package sba_pkg;

   localparam int SBA_ADDR_W = 32;
   localparam int SBA_DATA_W = 32;
   // block select sits on the three top address bits
   localparam int SBA_SEL_HI = 31;
   localparam int SBA_SEL_LO = 29;
   localparam logic [2:0] SBA_INSTR_BASE = 3'h0;
   localparam logic [2:0] SBA_DATA_BASE = 3'h4;
   // word address: byte bits dropped, low part counts, high part loads
   localparam int SBA_WORD_LSB = 2;
   localparam int SBA_COUNT_W = 8;
   localparam int SBA_UPPER_W = 6;
   localparam int SBA_MEM_AW = SBA_COUNT_W + SBA_UPPER_W;
   localparam int SBA_FIFO_DEPTH = 16;
   localparam int SBA_OR_INPUTS = 7;
   localparam int SBA_PEERS = SBA_OR_INPUTS - 1;

   typedef enum logic [2:0] {
      SBA_IDLE = 3'b001,
      SBA_IACC = 3'b010,
      SBA_DACC = 3'b100
   } sba_state_t;

endpackage

// file: core/sba_arbiter.sv
// sba_arbiter: burst acknowledge state machine, address load/count,
// ready generation, response merge and a fetch word fifo.
// assumes all processor pins are synchronous to mclk_i.
//
// Contract
// - merge all blocks' responses through active-low OR, seven inputs each
// - data ready merge output enabled only while test control is inactive
// - acknowledge only for valid, selected, instruction/data space requests
// - three states: idle, instruction access, data access
// - data access preempts an instruction burst after one idle cycle
// - idle is default; both burst acknowledges inactive there
// - preempted instruction burst passes one idle cycle before data access
// - instruction match: request, type low, top bits 000, no test, fifo room
// - data match: request, both types low, top bits 100, no test
// - instruction window at zero, data window at a different base
// - instruction state exits on data match or foreign instruction request
// - data state exits on instr match without prior burst, or foreign data
// - instruction acknowledge registered, set on match without data ack
// - data acknowledge registered, set on match without instruction ack or match
// - load captures new address on the next clock edge
// - load combinational, blocked by opposite ack or prior same-type load
// - counter increments on continued burst, never after bus invalid
// - ready after qualified load or continued burst, blocked by bus invalid
`timescale 1ns/100ps

module sba_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [$clog2(DEPTH+1)-1:0] level_o,
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int PW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH-1);
   localparam logic [LW-1:0] LVL_FULL = LW'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [LW-1:0] lvl_r, lvl_nxt;
   logic push, pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("sba_fifo: depth must be a power of two, at least 2");
   end

   assign in_ready_o = (lvl_r != LVL_FULL);
   assign out_valid_o = (lvl_r != '0);
   assign out_data_o = mem_r[rd_r];
   assign level_o = lvl_r;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb begin
      wr_nxt = push ? ((wr_r == PTR_LAST) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt = pop ? ((rd_r == PTR_LAST) ? '0 : rd_r + 1'b1) : rd_r;
      lvl_nxt = lvl_r;
      if (push && !pop) begin
         lvl_nxt = lvl_r + 1'b1;
      end else if (pop && !push) begin
         lvl_nxt = lvl_r - 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_r <= '0;
         rd_r <= '0;
         lvl_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   // storage has no reset; only entries behind valid are read
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_ent
         always_ff @(posedge mclk_i) begin
            if (push && wr_r == PW'(g)) begin
               mem_r[g] <= in_data_i;
            end
         end
      end
   endgenerate
endmodule // sba_fifo

////////////////////////////////////////////////////////////////////////////

module sba_arbiter #(
   parameter int PEERS = sba_pkg::SBA_PEERS,
   parameter int FIFO_DEPTH = sba_pkg::SBA_FIFO_DEPTH
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic instr_request_i,
   input wire logic instr_space_type_i,
   input wire logic data_request_i,
   input wire logic data_space_type_lo_i,
   input wire logic data_space_type_hi_i,
   input wire logic [sba_pkg::SBA_ADDR_W-1:0] addr_i,
   input wire logic test_takeover_i,
   input wire logic instr_burst_req_i,
   input wire logic data_burst_req_i,
   input wire logic bus_invalid_i,
   input wire logic [PEERS-1:0] peer_instr_ready_nxt_n_i,
   input wire logic [PEERS-1:0] peer_data_ready_nxt_n_i,
   input wire logic [sba_pkg::SBA_DATA_W-1:0] sram_rdata_i,
   input wire logic fetch_ready_i,
   output logic instr_burst_ack_o,
   output logic data_burst_ack_o,
   output logic instr_ready_resp_n_o,
   output logic data_ready_resp_n_o,
   output logic data_ready_oe_n_o,
   output logic [sba_pkg::SBA_MEM_AW-1:0] mem_addr_o,
   output logic [sba_pkg::SBA_DATA_W-1:0] fetch_data_o,
   output logic fetch_valid_o
);
   import sba_pkg::*;

   localparam int LW = $clog2(FIFO_DEPTH+1);
   localparam logic [LW-1:0] ROOM_MAX = LW'(FIFO_DEPTH-1);

   if (PEERS < 1 || PEERS > SBA_PEERS) begin : g_bad_peers
      $error("sba_arbiter: peer count outside one OR gate");
   end

   sba_state_t state_r, state_nxt;
   logic instr_load_delayed_r, instr_load_delayed_nxt;
   logic data_load_delayed_r, data_load_delayed_nxt;
   logic instr_burst_req_d_r, data_burst_req_delayed_r, bus_invalid_d_r;
   logic [SBA_COUNT_W-1:0] count_r, count_nxt;
   logic [SBA_UPPER_W-1:0] upper_r, upper_nxt;
   logic instr_ready_own_r, instr_ready_own_nxt, data_ready_own_nxt;
   logic instr_resp_n_r, instr_resp_n_nxt, data_resp_n_r, data_resp_n_nxt;
   logic data_oe_n_r, instr_burst_ack, data_burst_ack;
   logic instr_block_match, data_block_match;
   logic instr_exit_term, data_exit_term;
   logic addr_load, addr_increment, fifo_room;
   logic [LW-1:0] fifo_level;
   logic [SBA_SEL_HI-SBA_SEL_LO:0] sel;

   ////////////////////////////////////////////////////////////////////////
   // match and exit terms

   assign instr_burst_ack = (state_r == SBA_IACC);
   assign data_burst_ack = (state_r == SBA_DACC);
   assign sel = addr_i[SBA_SEL_HI:SBA_SEL_LO];
   // keep two slots free: a word may already be on its way in
   assign fifo_room = (fifo_level < ROOM_MAX);
   assign instr_block_match = instr_request_i & ~instr_space_type_i
              & (sel == SBA_INSTR_BASE) & ~test_takeover_i
              & fifo_room;
   assign data_block_match = data_request_i & ~data_space_type_lo_i
              & ~data_space_type_hi_i
              & (sel == SBA_DATA_BASE) & ~test_takeover_i;
   assign instr_exit_term = data_block_match
              | (instr_request_i & ~instr_block_match);
   assign data_exit_term = (instr_block_match & ~data_burst_req_delayed_r)
              | (data_request_i & ~data_block_match);

   ////////////////////////////////////////////////////////////////////////
   // burst acknowledge state machine

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SBA_IDLE: begin
            // instruction wins a tie; the pair never both ack
            if (instr_block_match) begin
               state_nxt = SBA_IACC;
            end else if (data_block_match) begin
               state_nxt = SBA_DACC;
            end
         end
         SBA_IACC: begin
            // preemption drops to idle, never straight to data access
            if (instr_exit_term) begin
               state_nxt = SBA_IDLE;
            end
         end
         SBA_DACC: begin
            if (data_exit_term) begin
               state_nxt = SBA_IDLE;
            end
         end
         default: state_nxt = SBA_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= SBA_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address load and count

   assign addr_load = (~data_burst_ack & instr_request_i
                       & ~instr_load_delayed_r)
                    | (~instr_burst_ack & data_request_i
                       & ~data_load_delayed_r);
   assign addr_increment = (instr_burst_req_d_r & ~bus_invalid_d_r
                            & instr_burst_ack)
                         | (data_burst_req_delayed_r & ~bus_invalid_d_r
                            & data_burst_ack);

   always_comb begin
      instr_load_delayed_nxt = ~data_burst_ack & instr_block_match
                             & ~instr_load_delayed_r;
      data_load_delayed_nxt = ~instr_burst_ack & data_block_match
                            & ~data_load_delayed_r;
      count_nxt = count_r;
      upper_nxt = upper_r;
      if (addr_load) begin
         count_nxt = addr_i[SBA_WORD_LSB +: SBA_COUNT_W];
         upper_nxt = addr_i[SBA_WORD_LSB+SBA_COUNT_W +: SBA_UPPER_W];
      end else if (addr_increment) begin
         count_nxt = count_r + 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         instr_load_delayed_r <= 1'b0;
         data_load_delayed_r <= 1'b0;
         instr_burst_req_d_r <= 1'b0;
         data_burst_req_delayed_r <= 1'b0;
         bus_invalid_d_r <= 1'b0;
         count_r <= '0;
         upper_r <= '0;
      end else begin
         instr_load_delayed_r <= instr_load_delayed_nxt;
         data_load_delayed_r <= data_load_delayed_nxt;
         instr_burst_req_d_r <= instr_burst_req_i;
         data_burst_req_delayed_r <= data_burst_req_i;
         bus_invalid_d_r <= bus_invalid_i;
         count_r <= count_nxt;
         upper_r <= upper_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ready and merged responses
   // ready is built one cycle early from the next values of its terms so
   // the pins come from flops with the same timing as the gate form

   always_comb begin
      instr_ready_own_nxt = (instr_load_delayed_nxt & ~bus_invalid_i)
         | (instr_burst_req_i & ~bus_invalid_i & instr_burst_ack);
      data_ready_own_nxt = (data_load_delayed_nxt & ~bus_invalid_i)
         | (data_burst_req_i & ~bus_invalid_i & data_burst_ack);
      // negative-logic OR: any low input drives the line low
      instr_resp_n_nxt = ~instr_ready_own_nxt
                       & (&peer_instr_ready_nxt_n_i);
      data_resp_n_nxt = ~data_ready_own_nxt
                      & (&peer_data_ready_nxt_n_i);
   end

   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         instr_ready_own_r <= 1'b0;
         instr_resp_n_r <= 1'b1;
         data_resp_n_r <= 1'b1;
         data_oe_n_r <= 1'b1;
      end else begin
         instr_ready_own_r <= instr_ready_own_nxt;
         instr_resp_n_r <= instr_resp_n_nxt;
         data_resp_n_r <= data_resp_n_nxt;
         // test hardware owns the data ready line while takeover is high
         data_oe_n_r <= test_takeover_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fetched words: each own instruction ready pushes the memory word unless the fifo is full

   sba_fifo #(
      .WIDTH(SBA_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .reset_n_i(reset_n_i),
      .in_data_i(sram_rdata_i),
      .in_valid_i(instr_ready_own_r),
      .in_ready_o(),
      .level_o(fifo_level),
      .out_data_o(fetch_data_o),
      .out_valid_o(fetch_valid_o),
      .out_ready_i(fetch_ready_i)
   );

   assign instr_burst_ack_o = state_r[1];
   assign data_burst_ack_o = state_r[2];
   assign instr_ready_resp_n_o = instr_resp_n_r;
   assign data_ready_resp_n_o = data_resp_n_r;
   assign data_ready_oe_n_o = data_oe_n_r;
   assign mem_addr_o = {upper_r, count_r};

endmodule // sba_arbiter

// file: verification/sba_sram_model.sv
// sba_sram_model: memory array stand-in for the fetch path.
// assumes a word address from the arbiter and zero-wait reads.
`timescale 1ns/100ps
module sba_sram_model (
   input wire logic [13:0] addr_i,
   output logic [31:0] rdata_o
);
   // word reads back its own address, so fifo order is visible
   assign rdata_o = {18'h0, addr_i};
endmodule // sba_sram_model

// file: verification/sba_arbiter_chk.sv
// sba_arbiter_chk: port-level checks of the burst arbiter.
// assumes bind into sba_arbiter, one clock domain.
`timescale 1ns/100ps
module sba_arbiter_chk #(
   parameter int PEERS = 6,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic reset_n_i,
   input wire logic instr_request_i,
   input wire logic instr_space_type_i,
   input wire logic data_request_i,
   input wire logic data_space_type_lo_i,
   input wire logic data_space_type_hi_i,
   input wire logic [31:0] addr_i,
   input wire logic test_takeover_i,
   input wire logic bus_invalid_i,
   input wire logic [PEERS-1:0] peer_instr_ready_nxt_n_i,
   input wire logic instr_burst_ack_o,
   input wire logic data_burst_ack_o,
   input wire logic instr_ready_resp_n_o,
   input wire logic data_ready_oe_n_o,
   input wire logic [13:0] mem_addr_o
);
   logic ia, da, im, dm;
   assign ia = instr_burst_ack_o;
   assign da = data_burst_ack_o;
   // fifo level is hidden here, so im is only an upper bound
   assign im = instr_request_i && !instr_space_type_i &&
      addr_i[31:29] == 3'h0 && !test_takeover_i;
   assign dm = data_request_i && !data_space_type_lo_i &&
      !data_space_type_hi_i && addr_i[31:29] == 3'h4 && !test_takeover_i;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   sequence preempt_s;
      ia && dm;
   endsequence
   sequence gap_s;
      !ia && !da;
   endsequence
   ack_excl_a: assert property (!(ia && da))
      else $error("both acks high");
   iack_cause_a: assert property ($rose(ia) |-> $past(im && !da))
      else $error("instr ack without match");
   dack_cause_a: assert property ($rose(da) |-> $past(dm && !ia))
      else $error("data ack without match");
   dack_set_a: assert property (dm && !ia && !instr_request_i |=> da)
      else $error("data ack not set");
   preempt_gap_a: assert property (preempt_s |=> gap_s)
      else $error("preempt missed idle gap");
   instr_exit_term_far_a: assert property (ia && instr_request_i && !im |=> !ia)
      else $error("instr ack held on foreign fetch");
   data_exit_term_far_a: assert property (da && data_request_i && !dm |=> !da)
      else $error("data ack held on foreign access");
   oe_follow_a: assert property ($past(reset_n_i) |->
      data_ready_oe_n_o == $past(test_takeover_i))
      else $error("ready enable not following test control");
   rdy_bus_invalid_a: assert property ($past(reset_n_i && bus_invalid_i &&
      &peer_instr_ready_nxt_n_i) |-> instr_ready_resp_n_o)
      else $error("ready after invalid bus");
   load_addr_a: assert property ($rose(ia) |->
      mem_addr_o == $past(addr_i[15:2]))
      else $error("address not loaded");
endmodule // sba_arbiter_chk
bind sba_arbiter sba_arbiter_chk #(.PEERS(PEERS), .FIFO_DEPTH(FIFO_DEPTH))
   chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
   .instr_request_i(instr_request_i),
   .instr_space_type_i(instr_space_type_i),
   .data_request_i(data_request_i),
   .data_space_type_lo_i(data_space_type_lo_i),
   .data_space_type_hi_i(data_space_type_hi_i), .addr_i(addr_i),
   .test_takeover_i(test_takeover_i), .bus_invalid_i(bus_invalid_i),
   .peer_instr_ready_nxt_n_i(peer_instr_ready_nxt_n_i),
   .instr_burst_ack_o(instr_burst_ack_o),
   .data_burst_ack_o(data_burst_ack_o),
   .instr_ready_resp_n_o(instr_ready_resp_n_o),
   .data_ready_oe_n_o(data_ready_oe_n_o), .mem_addr_o(mem_addr_o));

// file: verification/test_sba_arbiter.sv
// test_sba_arbiter: self-checking bench with a reference ack model.
// assumes sba_arbiter, its checker and sba_sram_model compiled first.
`timescale 1ns/100ps
module test_sba_arbiter;
   logic mclk_i, reset_n, ir, it, dr, dl, dh, tk, ib, db, bv, fr;
   logic ia, da, irn, drn, oen, fv;
   logic [31:0] a, rd, fd, r;
   logic [5:0] pi, pd;
   logic [13:0] ma;
   int mismatches, n_tests, n;
   bit mi, md, mt, dbq, im, dm, chk;
   bit mil, mdl, mrn, mdn, nil, ndl;
   sba_arbiter dut (.mclk_i(mclk_i), .reset_n_i(reset_n),
      .instr_request_i(ir), .instr_space_type_i(it), .data_request_i(dr),
      .data_space_type_lo_i(dl), .data_space_type_hi_i(dh), .addr_i(a),
      .test_takeover_i(tk), .instr_burst_req_i(ib), .data_burst_req_i(db),
      .bus_invalid_i(bv), .peer_instr_ready_nxt_n_i(pi),
      .peer_data_ready_nxt_n_i(pd), .sram_rdata_i(rd), .fetch_ready_i(fr),
      .instr_burst_ack_o(ia), .data_burst_ack_o(da),
      .instr_ready_resp_n_o(irn), .data_ready_resp_n_o(drn),
      .data_ready_oe_n_o(oen), .mem_addr_o(ma), .fetch_data_o(fd),
      .fetch_valid_o(fv));
   sba_sram_model mem (.addr_i(ma), .rdata_o(rd));
   initial begin
      mclk_i = 0;
      forever #5 mclk_i = ~mclk_i;
   end
   task automatic check(input logic [13:0] g, input logic [13:0] e);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // reference model; from idle an instruction match wins a tie
   always @(posedge mclk_i or negedge reset_n) begin
      if (!reset_n) begin
         {mi, md, mt, dbq, mil, mdl, mrn, mdn} <= 8'h23;
      end else begin
         im = ir && !it && a[31:29] == 3'h0 && !tk;
         dm = dr && !dl && !dh && a[31:29] == 3'h4 && !tk;
         nil = im && !md && !mil;
         ndl = dm && !mi && !mdl;
         {mi, md, mt, dbq} <= {im && !md || !(dm || ir && !im) && mi,
            dm && !mi && !(im && !md) || !(im && !dbq || dr && !dm) && md,
            tk, db};
         {mil, mdl} <= {nil, ndl};
         mrn <= !((nil || ib && mi) && !bv) && &pi;
         mdn <= !((ndl || db && md) && !bv) && &pd;
      end
   end
   always @(negedge mclk_i) if (chk) begin
      check(ia, mi);
      check(da, md);
      check(oen, mt);
      check(irn, mrn);
      check(drn, mdn);
   end
   initial begin
      {ir, it, dr, dl, dh, tk, ib, db, bv, fr} = 10'h1;
      {a, pi, pd, reset_n, chk} = {32'h0, 12'hFFF, 2'h1};
      void'($urandom(32'hB76873E4));
      repeat (16) @(posedge mclk_i);
      @(negedge mclk_i) reset_n = 1;
      check(ia | da, 1'b0);
      $display("reset test done");
      @(negedge mclk_i);
      {ir, ib, a} = {2'h3, 32'h40};
      @(negedge mclk_i);
      check(ma, 14'h10);
      check(irn, 1'b0);
      @(negedge mclk_i);
      check(ma, 14'h11);
      {ir, ib, dr, db, a} = {4'h3, 32'h80000080};
      repeat (3) @(negedge mclk_i);
      check(ma, 14'h21);
      check(drn, 1'b0);
      $display("preempt test done");
      repeat (3000) begin
         @(negedge mclk_i);
         r = $urandom;
         {ir, dr, ib, db} = r[3:0];
         {it, dl, dh, tk, bv} = {&r[5:4], &r[7:6], &r[9:8], &r[13:10], r[14]};
         a = $urandom;
         if (r[16]) a[30:29] = 2'h0;
         {pi, pd} = {5'h1F, r[20] | r[21], r[22] | r[23], 5'h1F};
      end
      $display("random test done");
      // mid-run reset, then one burst fills the fifo with the sink stalled
      {ir, it, dr, dl, dh, tk, ib, db, bv, chk} = 10'h0;
      reset_n = 0;
      repeat (2) @(negedge mclk_i);
      reset_n = 1;
      check(ia | da | fv, 1'b0);
      @(negedge mclk_i);
      {ir, ib, a, fr} = {2'h3, 32'h40, 1'b0};
      @(negedge mclk_i);
      ir = 0;
      repeat (20) @(negedge mclk_i);
      check(fv, 1'b1);
      // a new fetch is refused while full, so the burst is dropped
      ir = 1;
      @(negedge mclk_i);
      check(ia, 1'b0);
      {ir, ib, fr, n} = {3'h1, 32'h0};
      while (fv === 1'b1 && n < 20) begin
         check(fd[13:0], 14'h10 + n[13:0]);
         n++;
         @(negedge mclk_i);
      end
      check(n == 16, 1'b1);
      $display("fifo test done");
      give_verdict;
   end
   initial begin
      repeat (6000) @(posedge mclk_i);
      mismatches++;
      give_verdict;
   end
endmodule // test_sba_arbiter
